/* File: rtl/dpbs_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module dpbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_reset_n,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0]      wr_ptr_q;
   logic [PW:0]      rd_ptr_q;
   wire              full;
   wire              empty;
   wire              push;
   wire              pop;

   // Extra pointer bit tells full from empty
   assign full    = (wr_ptr_q[PW] != rd_ptr_q[PW])
                    && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
   assign empty   = (wr_ptr_q == rd_ptr_q);
   assign o_ready = ~full;
   assign o_valid = ~empty;
   assign o_data  = mem_q[rd_ptr_q[PW-1:0]];
   assign push    = i_valid & ~full;
   assign pop     = i_ready & ~empty;

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_q[wr_ptr_q[PW-1:0]] <= i_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_q + (PW+1)'(push);
         rd_ptr_q <= rd_ptr_q + (PW+1)'(pop);
      end
   end
endmodule // dpbs_fifo

/* File: rtl/dpbs_pkg.sv */
// Constants and types for the burst-of-two dual-port SRAM pin model.
// Assumes all pins are sampled on i_core_clk; the K, K#, C and C# clocks
// are plain inputs whose rising edges are found by sampling.
// Operation
// - Write data sampled on both input clock rises
// - Low write select at K rise starts write
// - Deasserted write select ignores write data
// - Read address captured at K rise of read
// - Nineteen address bits select a word pair
// - Address ignored for a deselected port
// - Read data driven on both output clock rises
// - Single-clock mode launches data on K pair
// - Low read select at K rise starts read
// - Deselected read finishes, then outputs float
// - Every read returns exactly two words
// - Accesses start only on K rising edge
// - K# rise also captures synchronous inputs
// - Output clock pair clocks out read data
// - Write address and second word on K#
// - Low word on C, high word on C#
// - Byte lane masks gate each written lane
package dpbs_pkg;

   localparam int ADDR_W     = 19;
   localparam int WORD_W     = 18;
   localparam int PAIR_W     = 2 * WORD_W;
   localparam int LANE_W     = 9;
   localparam int WORD_LANES = WORD_W / LANE_W;
   localparam int PAIR_LANES = 2 * WORD_LANES;
   localparam int MEM_DEPTH  = 1 << ADDR_W;
   localparam int FIFO_DEPTH = 32;

   localparam logic [WORD_W-1:0]     RST_Q     = 18'h00000;
   localparam logic                  RST_OE_N  = 1'b1;
   localparam logic [PAIR_W-1:0]     RST_PAIR  = 36'h000000000;
   localparam logic [WORD_LANES-1:0] RST_MASK  = 2'h3;

   typedef logic [ADDR_W-1:0] dpbs_addr_t;
   typedef logic [PAIR_W-1:0] dpbs_pair_t;

   // Write port sequencing
   typedef enum logic {
      WR_IDLE    = 1'b0,
      WR_WAIT_HI = 1'b1
   } dpbs_wr_e;

   // Read output phase, Gray order idle -> high -> done
   typedef enum logic [1:0] {
      RO_IDLE = 2'b00,
      RO_HIGH = 2'b01,
      RO_DONE = 2'b11
   } dpbs_ro_e;

   // One committed write: address, word pair, lane enables (active high)
   typedef struct packed {
      dpbs_addr_t            addr;
      dpbs_pair_t            data;
      logic [PAIR_LANES-1:0] lane_en;
   } dpbs_wr_entry_s;

   localparam int ENTRY_W = $bits(dpbs_wr_entry_s);

endpackage

/* File: rtl/dpbs_sram.sv */
// Pin-level burst-of-two SRAM with separate read and write data ports.
// Assumes the memory controller drives K/K#/C/C# as slow levels that
// i_core_clk samples; every rising edge is found by comparing with the last sample.
`timescale 1ns/1ps
module dpbs_sram (
   input  wire logic                                 i_core_clk,
   input  wire logic                                 i_reset_n,
   input  wire logic                                 i_k,
   input  wire logic                                 i_k_n,
   input  wire logic                                 i_c,
   input  wire logic                                 i_c_n,
   input  wire logic                                 i_read_port_select_n,
   input  wire logic                                 i_write_port_select_n,
   input  wire dpbs_pkg::dpbs_addr_t                 i_addr,
   input  wire logic [dpbs_pkg::WORD_W-1:0]          i_d,
   input  wire logic [dpbs_pkg::WORD_LANES-1:0]      i_byte_lane_mask_n,
   output logic      [dpbs_pkg::WORD_W-1:0]          o_q,
   output logic                                      o_q_oe_n,
   output logic                                      o_single_clock,
   output logic                                      o_write_full
);
   import dpbs_pkg::*;

   // Sampled clock levels for edge finding
   logic k_q;
   logic kn_q;
   logic c_q;
   logic cn_q;

   // Write port state
   dpbs_wr_e              wr_state_q;
   dpbs_wr_e              wr_state_d;
   logic [WORD_W-1:0]     wr_lo_q;
   logic [WORD_LANES-1:0] wr_lo_mask_n_q;

   // Read pipeline state
   logic       arm_q;
   logic       rdy_q;
   dpbs_pair_t cap_q;
   dpbs_pair_t obuf_q;
   logic [WORD_W-1:0] hi_q;
   dpbs_ro_e   ro_state_q;
   dpbs_ro_e   ro_state_d;
   logic       single_q;

   // Array, flip-flops addressed by index
   dpbs_pair_t mem_q [MEM_DEPTH];

   // FIFO between write capture and array commit
   dpbs_wr_entry_s push_entry;
   dpbs_wr_entry_s pop_entry;
   logic           fifo_in_ready;
   logic           fifo_out_valid;
   wire            fifo_push;
   wire            fifo_pop_ready;

   function automatic dpbs_pair_t lane_merge(input dpbs_pair_t old_v,
                                             input dpbs_pair_t new_v,
                                             input logic [PAIR_LANES-1:0] en);
      dpbs_pair_t r;
      r = old_v;
      for (int i = 0; i < PAIR_LANES; i++) begin
         if (en[i]) begin
            r[i*LANE_W +: LANE_W] = new_v[i*LANE_W +: LANE_W];
         end
      end
      return r;
   endfunction

   // Edge detection on the sampled clocks
   wire k_rise  = i_k & ~k_q;
   wire kn_rise = i_k_n & ~kn_q;
   wire c_rise  = i_c & ~c_q;
   wire cn_rise = i_c_n & ~cn_q;

   // Output clock pair, or the K pair in single-clock mode
   wire oclk_p_rise = single_q ? k_rise : c_rise;
   wire oclk_n_rise = single_q ? kn_rise : cn_rise;

   // Access requests exist only at K rises
   wire rd_req = k_rise & ~i_read_port_select_n;
   wire wr_req = k_rise & ~i_write_port_select_n;

   // Read data view as of this edge; the K rise promotes the capture
   wire        promote  = k_rise & arm_q;
   wire        rdy_now  = k_rise ? arm_q : rdy_q;
   dpbs_pair_t obuf_now;
   assign obuf_now = promote ? cap_q : obuf_q;
   wire        launch   = oclk_p_rise & rdy_now;
   wire        send_hi  = oclk_n_rise & (ro_state_q == RO_HIGH);
   wire        float_now = oclk_p_rise & ~rdy_now
                          & (ro_state_q != RO_IDLE);

   // Second word and address arrive together on K#
   assign fifo_push = (wr_state_q == WR_WAIT_HI) & kn_rise;
   assign push_entry.addr    = i_addr;
   assign push_entry.data    = {i_d, wr_lo_q};
   assign push_entry.lane_en = {~i_byte_lane_mask_n,
                                ~wr_lo_mask_n_q};

   // Array has one access port: a read start stalls the commit
   assign fifo_pop_ready = ~rd_req;

   dpbs_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_valid    (fifo_push),
      .o_ready    (fifo_in_ready),
      .i_data     (push_entry),
      .o_valid    (fifo_out_valid),
      .i_ready    (fifo_pop_ready),
      .o_data     (pop_entry)
   );

   // Write sequencing
   always_comb begin
      wr_state_d = wr_state_q;
      unique case (wr_state_q)
         WR_IDLE: begin
            if (wr_req) begin
               wr_state_d = WR_WAIT_HI;
            end
         end
         WR_WAIT_HI: begin
            if (kn_rise) begin
               wr_state_d = WR_IDLE;
            end
         end
      endcase
   end

   // Read output phase
   always_comb begin
      ro_state_d = ro_state_q;
      unique case (ro_state_q)
         RO_IDLE: begin
            if (launch) begin
               ro_state_d = RO_HIGH;
            end
         end
         RO_HIGH: begin
            if (send_hi) begin
               ro_state_d = RO_DONE;
            end
         end
         RO_DONE: begin
            if (launch) begin
               ro_state_d = RO_HIGH;
            end else if (float_now) begin
               ro_state_d = RO_IDLE;
            end
         end
         default: begin
            ro_state_d = RO_IDLE;
         end
      endcase
   end

   // Clock sampling; strap caught while reset is held
   always_ff @(posedge i_core_clk) begin
      k_q  <= i_k;
      kn_q <= i_k_n;
      c_q  <= i_c;
      cn_q <= i_c_n;
      if (!i_reset_n) begin
         single_q <= i_c & i_c_n;
      end
   end

   // Commit of a whole word pair in one update
   always_ff @(posedge i_core_clk) begin
      if (fifo_out_valid && fifo_pop_ready) begin
         mem_q[pop_entry.addr] <= lane_merge(mem_q[pop_entry.addr],
                                             pop_entry.data,
                                             pop_entry.lane_en);
      end
   end

   // First write word; nothing captured while deselected
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         wr_state_q     <= WR_IDLE;
         wr_lo_q        <= RST_Q;
         wr_lo_mask_n_q <= RST_MASK;
      end else begin
         wr_state_q <= wr_state_d;
         if (wr_req && wr_state_q == WR_IDLE) begin
            wr_lo_q        <= i_d;
            wr_lo_mask_n_q <= i_byte_lane_mask_n;
         end
      end
   end

   // Read capture; address used only under an active select
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         arm_q  <= 1'b0;
         cap_q  <= RST_PAIR;
         obuf_q <= RST_PAIR;
      end else begin
         if (k_rise) begin
            arm_q <= ~i_read_port_select_n;
         end
         if (rd_req) begin
            cap_q <= mem_q[i_addr];
         end
         obuf_q <= obuf_now;
      end
   end

   // Output registers on the output clock pair
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         rdy_q      <= 1'b0;
         ro_state_q <= RO_IDLE;
         hi_q       <= RST_Q;
         o_q        <= RST_Q;
         o_q_oe_n   <= RST_OE_N;
      end else begin
         rdy_q      <= rdy_now & ~launch;
         ro_state_q <= ro_state_d;
         if (launch) begin
            o_q      <= obuf_now[WORD_W-1:0];
            hi_q     <= obuf_now[PAIR_W-1:WORD_W];
            o_q_oe_n <= 1'b0;
         end else if (send_hi) begin
            o_q <= hi_q;
         end else if (float_now) begin
            o_q_oe_n <= 1'b1;
         end
      end
   end

   // Status outputs held in flops
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_single_clock <= 1'b0;
         o_write_full   <= 1'b0;
      end else begin
         o_single_clock <= single_q;
         // Too late to stop a push; full means writes are now lost
         o_write_full   <= ~fifo_in_ready;
      end
   end
endmodule // dpbs_sram

/* File: test/dpbs_ctl_model.sv */
// Memory controller model driving the SRAM pins one K cycle at a time.
// Assumes calls start just after a core clock edge; a level holds 2 cycles.
`timescale 1ns/1ps
module dpbs_ctl_model (
   input  wire logic                            i_core_clk,
   input  wire logic                            i_strap,
   input  wire logic [dpbs_pkg::WORD_W-1:0]     i_q,
   input  wire logic                            i_q_oe_n,
   output logic                                 o_k,
   output logic                                 o_k_n,
   output logic                                 o_c,
   output logic                                 o_c_n,
   output logic                                 o_read_port_select_n,
   output logic                                 o_write_port_select_n,
   output dpbs_pkg::dpbs_addr_t                 o_addr,
   output logic [dpbs_pkg::WORD_W-1:0]          o_d,
   output logic [dpbs_pkg::WORD_LANES-1:0]      o_mask_n
);
   import dpbs_pkg::*;
   // K pair parked low, C pair at the strap, so the first K rise after reset is a real edge
   task automatic park();
      o_k <= 1'b0;
      o_k_n <= 1'b0;
      o_c <= i_strap;
      o_c_n <= i_strap;
      o_read_port_select_n <= 1'b1;
      o_write_port_select_n <= 1'b1;
      o_addr <= '0;
      o_d <= '0;
      o_mask_n <= 2'h3;
   endtask
   task automatic half(input logic p, input logic rn, input logic wn,
         input dpbs_addr_t a, input logic [WORD_W-1:0] d,
         input logic [1:0] m, output logic [WORD_W-1:0] q, output logic oe);
      o_k <= p;
      o_k_n <= !p;
      o_c <= i_strap | p;
      o_c_n <= i_strap | !p;
      o_read_port_select_n <= rn;
      o_write_port_select_n <= wn;
      o_addr <= a;
      o_d <= d;
      o_mask_n <= m;
      @(posedge i_core_clk);
      q = i_q;
      oe = i_q_oe_n;
      @(posedge i_core_clk);
   endtask
   // Word pair low half on K, high half with the write address on K#
   task automatic kc(input logic rd, input logic wr, input dpbs_addr_t ra,
         input dpbs_addr_t wa, input dpbs_pair_t wd, input logic [3:0] m,
         output logic [WORD_W-1:0] qk, output logic [WORD_W-1:0] qn,
         output logic on);
      logic ok;
      half(1'b1, !rd, !wr, ra, wd[WORD_W-1:0], m[1:0], qk, ok);
      half(1'b0, 1'b1, 1'b1, wa, wd[PAIR_W-1:WORD_W], m[3:2], qn, on);
   endtask
endmodule // dpbs_ctl_model

/* File: test/dpbs_sram_chk.sv */
// Assertions on the SRAM pin block, bound to its ports.
// Assumes every K, K#, C and C# level lasts two or more core cycles.
`timescale 1ns/1ps
module dpbs_sram_chk (
   input wire logic                        i_core_clk,
   input wire logic                        i_reset_n,
   input wire logic                        i_k,
   input wire logic                        i_k_n,
   input wire logic                        i_c,
   input wire logic                        i_c_n,
   input wire logic                        i_read_port_select_n,
   input wire logic [dpbs_pkg::WORD_W-1:0] o_q,
   input wire logic                        o_q_oe_n,
   input wire logic                        o_single_clock
);
   import dpbs_pkg::*;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   logic       k_q, kn_q, c_q, cn_q;
   logic [7:0] since_rd_q;
   wire        k_rise   = i_k & ~k_q;
   wire        kn_rise  = i_k_n & ~kn_q;
   wire        c_rise   = i_c & ~c_q;
   wire        cn_rise  = i_c_n & ~cn_q;
   wire        pos_out  = o_single_clock ? k_rise : c_rise;
   wire        neg_out  = o_single_clock ? kn_rise : cn_rise;
   wire        rd_start = k_rise & ~i_read_port_select_n;
   always_ff @(posedge i_core_clk) begin
      k_q  <= i_k;
      kn_q <= i_k_n;
      c_q  <= i_c;
      cn_q <= i_c_n;
   end
   // Saturates, so a long idle spell cannot wrap into a false pass
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         since_rd_q <= 8'hFF;
      end else if (rd_start) begin
         since_rd_q <= 8'h00;
      end else if (since_rd_q != 8'hFF) begin
         since_rd_q <= since_rd_q + 8'h01;
      end
   end
   sequence s_drive;
      $fell(o_q_oe_n);
   endsequence
   sequence s_hold4;
      (!o_q_oe_n) [*4];
   endsequence
   drive_launch_a: assert property (s_drive |-> $past(pos_out))
      else $error("drive began off a positive output clock rise");
   data_edge_a: assert property ($changed(o_q) |-> $past(pos_out | neg_out))
      else $error("read data moved off an output clock rise");
   read_first_a: assert property (s_drive |-> since_rd_q < 8'hC8)
      else $error("outputs driven with no read started");
   float_edge_a: assert property ($rose(o_q_oe_n) |-> $past(pos_out))
      else $error("outputs floated off a positive output clock rise");
   burst_two_a: assert property (s_drive |-> s_hold4)
      else $error("burst cut short");
   read_answer_a: assert property (rd_start |-> ##[1:60] !o_q_oe_n)
      else $error("read never answered");
   strap_load_a: assert property ($rose(i_reset_n) |=>
      o_single_clock == $past(i_c & i_c_n, 2))
      else $error("clock mode strap taken wrongly");
   strap_hold_a: assert property (i_reset_n && $past(i_reset_n) &&
      $past(i_reset_n, 2) |-> $stable(o_single_clock))
      else $error("clock mode changed in operation");
endmodule // dpbs_sram_chk
bind dpbs_sram dpbs_sram_chk u_chk (.i_core_clk, .i_reset_n, .i_k, .i_k_n,
   .i_c, .i_c_n, .i_read_port_select_n, .o_q, .o_q_oe_n, .o_single_clock);

/* File: test/tb_top.sv */
// Self-checking bench for the burst-of-two SRAM pin block.
// Assumes the controller model paces the pin clocks at two cycles a level.
`timescale 1ns/1ps
module tb_top;
   import dpbs_pkg::*;
   localparam dpbs_pair_t P1 = 36'h123456789;
   localparam dpbs_pair_t P2 = 36'hFEDCBA987;
   localparam dpbs_pair_t P3 = 36'h5A5A5A5A5;
   localparam dpbs_pair_t E2 = {P2[35:27], P1[26:9], P2[8:0]};
   localparam dpbs_addr_t A1 = 19'h00123;
   localparam dpbs_addr_t A2 = 19'h40000;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  strap = 1'b0;
   logic                  k, k_n, c, c_n, rd_sel_n, wr_sel_n;
   logic                  oe_n, single, full;
   dpbs_addr_t            addr;
   logic [WORD_W-1:0]     d, q, qk, qn;
   logic [WORD_LANES-1:0] mask_n;
   logic                  on;
   int                    n_mismatch = 0;
   int                    checked = 0;
   initial begin
      forever #5 clk = ~clk;
   end
   dpbs_ctl_model u_ctl (.i_core_clk(clk), .i_strap(strap), .i_q(q),
      .i_q_oe_n(oe_n), .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n),
      .o_read_port_select_n(rd_sel_n), .o_write_port_select_n(wr_sel_n),
      .o_addr(addr), .o_d(d), .o_mask_n(mask_n));
   dpbs_sram uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_k(k), .i_k_n(k_n),
      .i_c(c), .i_c_n(c_n), .i_read_port_select_n(rd_sel_n),
      .i_write_port_select_n(wr_sel_n), .i_addr(addr), .i_d(d),
      .i_byte_lane_mask_n(mask_n), .o_q(q), .o_q_oe_n(oe_n),
      .o_single_clock(single), .o_write_full(full));
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic rst();
      rst_n <= 1'b0;
      u_ctl.park();
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   // Idle bus shows the inverse of its last data and K address; the K# address repeats the last one
   task automatic idle();
      u_ctl.kc(1'b0, 1'b0, ~addr, addr, ~{d, d}, 4'hF, qk, qn, on);
   endtask
   task automatic wr(input dpbs_addr_t a, input dpbs_pair_t wd,
         input logic [3:0] m);
      u_ctl.kc(1'b0, 1'b1, ~a, a, wd, m, qk, qn, on);
   endtask
   task automatic rd(input dpbs_addr_t a, input dpbs_pair_t exp,
         input logic w, input dpbs_addr_t wa, input dpbs_pair_t wd);
      u_ctl.kc(1'b1, w, a, wa, wd, 4'h0, qk, qn, on);
      idle();
      check(36'(qn), 36'(exp[17:0]));
      check(36'(on), 36'h000000000);
      idle();
      check(36'(qk), 36'(exp[35:18]));
      check(36'(on), 36'h000000001);
   endtask
   task automatic t_basic();
      wr(A1, P1, 4'h0);
      rd(A1, P1, 1'b0, A1, P3);
      check(36'(full), 36'h000000000);
   endtask
   task automatic t_lanes();
      wr(A1, P2, 4'h6);
      rd(A1, E2, 1'b0, A1, P3);
   endtask
   task automatic t_desel();
      u_ctl.kc(1'b0, 1'b0, A1, A1, P3, 4'h0, qk, qn, on);
      rd(A1, E2, 1'b0, A1, P3);
   endtask
   task automatic t_top();
      wr(19'h7FFFF, P3, 4'h0);
      wr(19'h3FFFF, P1, 4'h0);
      rd(19'h7FFFF, P3, 1'b0, A1, P1);
      rd(19'h3FFFF, P1, 1'b0, A1, P1);
   endtask
   task automatic t_conc();
      rd(A1, E2, 1'b1, A2, P3);
      rd(A2, P3, 1'b0, A1, P1);
   endtask
   // Strap only counts at reset; memory survives the second reset
   task automatic t_single();
      // Strap must settle before the model parks the C pins on it
      strap <= 1'b1;
      @(posedge clk);
      rst();
      idle();
      check(36'(single), 36'h000000001);
      rd(A1, E2, 1'b0, A1, P3);
   endtask
   initial begin
      rst();
      idle();
      check(36'(single), 36'h000000000);
      t_basic();
      t_lanes();
      t_desel();
      t_top();
      t_conc();
      t_single();
      conclude();
   end
   initial begin
      #50000;
      n_mismatch++;
      conclude();
   end
endmodule // tb_top
